// ==== core/clk_mode_cfg.svh ====
// Register map, field positions, reset values and timing counts.
`ifndef CLK_MODE_CFG_SVH
`define CLK_MODE_CFG_SVH
`define SMC_ADDR_CTRL 12'h000
`define SMC_ADDR_CTRL2 12'h004
`define SMC_ADDR_STAT 12'h008
`define SMC_CTRL_RESET 8'h03
`define SMC_BIT_SEL 0
`define SMC_BIT_IDLE 1
`define SMC_BIT_HRDY 2
`define SMC_BIT_LRDY 3
`define SMC_LCS_LSB 5
`define SMC_KEEP_BIT 7
`define SMC_LRDY_CYC 4'h2
`define SMC_HRDY_CYC 4'hF
`endif

// ==== core/clk_mode_pkg.sv ====
// Types shared by the clock and power mode controller.
package clk_mode_pkg;
  typedef enum logic [2:0] {
    RUN, DEEP_SLEEP, LIGHT_SLEEP, IDLE_NOCLK, IDLE_CLK
  } pmode_t;
endpackage

// ==== core/sys_clk_ctrl.sv ====
// Clock source selection and halt mode control with APB registers.
`timescale 1ns/1ns
`include "clk_mode_cfg.svh"
module sys_clk_ctrl #(
  parameter int DIV_W = 6
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // CPU halt and wake
  input wire logic HALT_I,
  input wire logic WAKE_I,
  input wire logic WDT_EN_I,
  input wire logic VDET_EN_I,
  // Oscillator ticks, one cycle each
  input wire logic HRC_TICK_I,
  input wire logic LRC_TICK_I,
  // Clock enables and status
  output logic SYS_CLK_EN_O,
  output logic CPU_RUN_O,
  output logic HRC_ON_O,
  output logic SUB_CLK_EN_O,
  output logic WDT_CLEAR_O,
  output logic [2:0] MODE_O,
  output logic PWR_DOWN_FLAG_O,
  output logic WDT_TIMEOUT_FLAG_O
);
  if (DIV_W != 6) begin : g_div_w_check
    $error("DIV_W must be 6");
  end

  logic [7:0] ctrl_reg;
  logic keep_reg;
  logic lrdy_reg, hrdy_reg;
  logic [3:0] lcnt_reg, hcnt_reg;
  logic pdf_reg, to_reg;
  clk_mode_pkg::pmode_t mode_reg;
  logic [DIV_W-1:0] div_reg;
  logic sys_tick, tick_sel;
  logic wr, rd;

  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  // Read data is loaded in the setup cycle, so it already stands at the
  // access edge where the master takes it with zero wait states.
  assign rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I &
    (PADDR_I != `SMC_ADDR_CTRL) & (PADDR_I != `SMC_ADDR_CTRL2) &
    (PADDR_I != `SMC_ADDR_STAT);

  // Select code to low clock tick; used by the system clock gating and the source switch.
  function automatic logic low_tick(input logic [2:0] code,
      input logic [DIV_W-1:0] div, input logic ltick, input logic htick);
    logic r;
    r = 1'b0;
    unique case (code)
      3'h0, 3'h1: r = ltick;
      3'h2: r = htick & (div[5:0] == 6'h3F);
      3'h3: r = htick & (div[4:0] == 5'h1F);
      3'h4: r = htick & (div[3:0] == 4'hF);
      3'h5: r = htick & (div[2:0] == 3'h7);
      3'h6: r = htick & (div[1:0] == 2'h3);
      3'h7: r = htick & div[0];
    endcase
    return r;
  endfunction

  // Software-writable bits; status bits and bit 4 are not stored.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ctrl_reg <= `SMC_CTRL_RESET;
      keep_reg <= 1'b0;
    end else if (wr && PADDR_I == `SMC_ADDR_CTRL) begin
      ctrl_reg <= PWDATA_I[7:0] & 8'hE3;
    end else if (wr && PADDR_I == `SMC_ADDR_CTRL2) begin
      keep_reg <= PWDATA_I[`SMC_KEEP_BIT];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd) begin
      unique case (PADDR_I)
        `SMC_ADDR_CTRL: PRDATA_O <= {24'h00_0000, ctrl_reg[7:5], 1'b0,
          lrdy_reg, hrdy_reg, ctrl_reg[1:0]};
        `SMC_ADDR_CTRL2: PRDATA_O <= {24'h00_0000, keep_reg, 7'h00};
        `SMC_ADDR_STAT: PRDATA_O <= {24'h00_0000, 3'h0, to_reg, pdf_reg,
          3'(mode_reg)};
        default: PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  logic lrc_sel;
  assign lrc_sel = ~ctrl_reg[`SMC_BIT_SEL] & ~ctrl_reg[7] & ~ctrl_reg[6];
  logic halted;
  assign halted = mode_reg != clk_mode_pkg::RUN;

  // Halt mode selection.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      mode_reg <= clk_mode_pkg::RUN;
    end else if (halted && WAKE_I) begin
      mode_reg <= clk_mode_pkg::RUN;
    end else if (!halted && HALT_I) begin
      if (ctrl_reg[`SMC_BIT_IDLE]) begin
        mode_reg <= keep_reg ? clk_mode_pkg::IDLE_CLK
                             : clk_mode_pkg::IDLE_NOCLK;
      end else if (WDT_EN_I || VDET_EN_I) begin
        mode_reg <= clk_mode_pkg::LIGHT_SLEEP;
      end else begin
        mode_reg <= clk_mode_pkg::DEEP_SLEEP;
      end
    end
  end

  // Power-down and timeout flags; timeout is never set, only cleared at reset and halt entry.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      pdf_reg <= 1'b0;
      to_reg <= 1'b0;
    end else if (!halted && HALT_I) begin
      pdf_reg <= 1'b1;
      to_reg <= 1'b0;
    end
  end

  // Fast oscillator divider; counts only while the oscillator runs.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      div_reg <= '0;
    end else if (HRC_ON_O && HRC_TICK_I) begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // Ready flags count ticks of their own oscillator after wake.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || mode_reg == clk_mode_pkg::DEEP_SLEEP) begin
      lrdy_reg <= 1'b0;
      lcnt_reg <= 4'h0;
    end else if (!lrdy_reg && LRC_TICK_I) begin
      lcnt_reg <= lcnt_reg + 4'h1;
      lrdy_reg <= (lcnt_reg + 4'h1) >= `SMC_LRDY_CYC;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !HRC_ON_O) begin
      hrdy_reg <= 1'b0;
      hcnt_reg <= 4'h0;
    end else if (!hrdy_reg && HRC_TICK_I) begin
      hcnt_reg <= hcnt_reg + 4'h1;
      hrdy_reg <= (hcnt_reg + 4'h1) >= `SMC_HRDY_CYC;
    end
  end

  // Source switch takes effect on a tick of the outgoing source, or at any cycle
  // while the selected fast oscillator is off, so no shortened pulse appears on the system clock enable.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      tick_sel <= 1'b1;
    end else if (sys_tick || (tick_sel && !HRC_ON_O)) begin
      tick_sel <= ctrl_reg[`SMC_BIT_SEL];
    end
  end

  assign sys_tick = tick_sel ? HRC_TICK_I
    : low_tick(ctrl_reg[7:5], div_reg, LRC_TICK_I, HRC_TICK_I);

  // Fast RC stops in slow mode on low RC, and in clockless halt modes.
  assign HRC_ON_O = ~(lrc_sel & ~tick_sel) &
    ~(mode_reg == clk_mode_pkg::DEEP_SLEEP ||
      mode_reg == clk_mode_pkg::LIGHT_SLEEP ||
      mode_reg == clk_mode_pkg::IDLE_NOCLK);
  assign SYS_CLK_EN_O = sys_tick &
    (mode_reg == clk_mode_pkg::RUN || mode_reg == clk_mode_pkg::IDLE_CLK);
  assign CPU_RUN_O = ~halted;
  assign SUB_CLK_EN_O = LRC_TICK_I & (mode_reg != clk_mode_pkg::DEEP_SLEEP);
  assign WDT_CLEAR_O = (~halted & HALT_I) |
    (mode_reg == clk_mode_pkg::DEEP_SLEEP);
  assign MODE_O = mode_reg;
  assign PWR_DOWN_FLAG_O = pdf_reg;
  assign WDT_TIMEOUT_FLAG_O = to_reg;

  a_bit4_zero: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    rd && PADDR_I == `SMC_ADDR_CTRL |=> PRDATA_O[4] == 1'b0)
    else $error("bit 4 read nonzero");
  a_idle_enter: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !halted && HALT_I && ctrl_reg[1] |=>
    mode_reg inside {clk_mode_pkg::IDLE_CLK, clk_mode_pkg::IDLE_NOCLK})
    else $error("halt with idle enable not idle");
  a_idle_keep: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !halted && HALT_I && ctrl_reg[1] && keep_reg |=>
    mode_reg == clk_mode_pkg::IDLE_CLK)
    else $error("clock keep ignored");
  a_deep_sleep: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !halted && HALT_I && !ctrl_reg[1] && !WDT_EN_I && !VDET_EN_I |=>
    mode_reg == clk_mode_pkg::DEEP_SLEEP && !SUB_CLK_EN_O)
    else $error("deep sleep not entered");
  a_vdet_block: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !halted && HALT_I && VDET_EN_I |=>
    mode_reg != clk_mode_pkg::DEEP_SLEEP)
    else $error("deep sleep with detector on");
  a_pdf_set: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !halted && HALT_I |=> pdf_reg && !to_reg)
    else $error("flags not updated at halt");
  a_hrc_stop: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    lrc_sel && !tick_sel |-> !HRC_ON_O)
    else $error("fast oscillator running on low rc");
  a_hrdy_low: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg == clk_mode_pkg::IDLE_NOCLK |=> !hrdy_reg)
    else $error("high ready set while stopped");
  a_lrdy_low: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg == clk_mode_pkg::DEEP_SLEEP |=> !lrdy_reg)
    else $error("low ready set in deep sleep");
  a_clk_stop: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg == clk_mode_pkg::IDLE_NOCLK |-> !SYS_CLK_EN_O)
    else $error("system clock runs in idle without clock");
  a_sel_fast: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    tick_sel && mode_reg == clk_mode_pkg::RUN |->
    SYS_CLK_EN_O == HRC_TICK_I)
    else $error("fast clock not passed");

  // Checks on slow clock selection, the switch between sources and unstored control bits.
  a_lrc_code0: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !tick_sel && ctrl_reg[7:5] == 3'h0 && mode_reg == clk_mode_pkg::RUN
    |-> SYS_CLK_EN_O == LRC_TICK_I)
    else $error("code 0 not on low rc");
  a_lrc_code1: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !tick_sel && ctrl_reg[7:5] == 3'h1 && mode_reg == clk_mode_pkg::RUN
    |-> SYS_CLK_EN_O == LRC_TICK_I)
    else $error("code 1 not on low rc");
  a_div_on_fast: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !tick_sel && ctrl_reg[7:6] != 2'h0 && SYS_CLK_EN_O
    |-> HRC_TICK_I)
    else $error("divided clock without fast tick");
  a_div2_rate: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !tick_sel && ctrl_reg[7:5] == 3'h7 && SYS_CLK_EN_O
    |-> div_reg[0])
    else $error("divide by two tick misplaced");
  a_tick_follow: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    tick_sel && sys_tick
    |-> HRC_TICK_I)
    else $error("fast source tick without fast tick");
  a_hrc_fast: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    ctrl_reg[0] && mode_reg == clk_mode_pkg::RUN
    |-> HRC_ON_O)
    else $error("fast oscillator off in normal mode");
  a_hrc_div: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !ctrl_reg[0] && ctrl_reg[7:6] != 2'h0 && mode_reg == clk_mode_pkg::RUN
    |-> HRC_ON_O)
    else $error("fast oscillator off while divided");
  a_div_stop: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !HRC_ON_O
    |=> $stable(div_reg))
    else $error("divider runs with oscillator off");
  a_switch_tick: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !$stable(tick_sel)
    |-> $past(sys_tick) || !$past(HRC_ON_O))
    else $error("source switched off a tick");
  a_bit4_store: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    ctrl_reg[4:2] == 3'h0)
    else $error("unstored control bits set");

  // Checks on halt entry, wake and the clocks kept in each halt mode.
  a_halt_ignored: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    halted && HALT_I && !WAKE_I
    |=> $stable(mode_reg))
    else $error("halt taken while halted");
  a_wake_run: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    halted && WAKE_I
    |=> mode_reg == clk_mode_pkg::RUN)
    else $error("wake did not return to run");
  a_cpu_stop: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    halted
    |-> !CPU_RUN_O)
    else $error("cpu runs while halted");
  a_light_sleep: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !halted && HALT_I && !ctrl_reg[1] && (WDT_EN_I || VDET_EN_I)
    |=> mode_reg == clk_mode_pkg::LIGHT_SLEEP)
    else $error("light sleep not entered");
  a_idle_noclk: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !halted && HALT_I && ctrl_reg[1] && !keep_reg
    |=> mode_reg == clk_mode_pkg::IDLE_NOCLK)
    else $error("idle without clock not entered");
  a_sub_noclk: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg == clk_mode_pkg::IDLE_NOCLK
    |-> SUB_CLK_EN_O == LRC_TICK_I)
    else $error("substitute clock stopped in idle");
  a_sub_light: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg == clk_mode_pkg::LIGHT_SLEEP
    |-> SUB_CLK_EN_O == LRC_TICK_I)
    else $error("substitute clock stopped in light sleep");
  a_sub_idleclk: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg == clk_mode_pkg::IDLE_CLK
    |-> SUB_CLK_EN_O == LRC_TICK_I)
    else $error("substitute clock stopped in idle with clock");
  a_idleclk_run: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg == clk_mode_pkg::IDLE_CLK && tick_sel
    |-> SYS_CLK_EN_O == HRC_TICK_I)
    else $error("system clock stopped in idle with clock");
  a_sleep_noclk: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg inside {clk_mode_pkg::DEEP_SLEEP, clk_mode_pkg::LIGHT_SLEEP}
    |-> !SYS_CLK_EN_O && !HRC_ON_O)
    else $error("clock runs in sleep");
  a_wdt_clear: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg == clk_mode_pkg::DEEP_SLEEP
    |-> WDT_CLEAR_O)
    else $error("watchdog not held clear in deep sleep");
  a_wdt_halt: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !halted && HALT_I
    |-> WDT_CLEAR_O)
    else $error("watchdog not cleared at halt");
  a_pdf_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    pdf_reg
    |=> pdf_reg)
    else $error("power-down flag lost");
  a_to_clear: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    halted
    |-> !to_reg)
    else $error("timeout flag set in halt");

  // Checks on the oscillator ready flags.
  a_hrdy_off: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !HRC_ON_O
    |=> !hrdy_reg)
    else $error("high ready kept with oscillator off");
  a_hrdy_sleep: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    mode_reg == clk_mode_pkg::DEEP_SLEEP
    |=> !hrdy_reg)
    else $error("high ready set in deep sleep");
  a_hrdy_count: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $rose(hrdy_reg)
    |-> hcnt_reg == 4'hF)
    else $error("high ready rose early");
  a_lrdy_count: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $rose(lrdy_reg)
    |-> lcnt_reg == 4'h2)
    else $error("low ready rose early");
  a_lrdy_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    lrdy_reg && mode_reg != clk_mode_pkg::DEEP_SLEEP
    |=> lrdy_reg)
    else $error("low ready dropped outside deep sleep");
endmodule

// ==== testbench/osc_model.sv ====
// Oscillator tick source standing in for the fast and low RC oscillators.
`timescale 1ns/1ns
module osc_model (
  // Clock, reset and fast oscillator enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hrc_on_i,
  // Oscillator ticks
  output logic hrc_tick_o,
  output logic lrc_tick_o
);
  logic [2:0] cnt_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
  // A stopped fast oscillator gives no ticks, so a design that keeps
  // using it after switching it off shows a dead system clock.
  assign hrc_tick_o = hrc_on_i & cnt_reg[0];
  assign lrc_tick_o = (cnt_reg == 3'h7);
endmodule

// ==== testbench/sys_clk_ctrl_tb.sv ====
// Self-checking bench for the clock and power mode controller.
`timescale 1ns/1ns
module sys_clk_ctrl_tb;
  logic clk, rst, psel, penable, pwrite, halt, wake, wdt_en, vdet_en;
  logic pready, pslverr, sys_en, cpu_run, hrc_on, sub_en, power_down_flag, tof;
  logic htick, ltick, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] mode;
  logic [2:0] exp_mode [5] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
  int n_errors = 0;
  int checked = 0;
  int n_sys, n_sub, e;
  sys_clk_ctrl i_sys_clk_ctrl (.CLK_SYS_I(clk), .RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .HALT_I(halt),
    .WAKE_I(wake), .WDT_EN_I(wdt_en), .VDET_EN_I(vdet_en),
    .HRC_TICK_I(htick), .LRC_TICK_I(ltick), .SYS_CLK_EN_O(sys_en),
    .CPU_RUN_O(cpu_run), .HRC_ON_O(hrc_on), .SUB_CLK_EN_O(sub_en),
    .WDT_CLEAR_O(), .MODE_O(mode), .PWR_DOWN_FLAG_O(power_down_flag),
    .WDT_TIMEOUT_FLAG_O(tof));
  osc_model i_osc_model (.clk_i(clk), .rst_i(rst), .hrc_on_i(hrc_on),
    .hrc_tick_o(htick), .lrc_tick_o(ltick));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Read data and error are taken at the edge where pready is high;
  // one idle cycle follows each transfer.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_errors++;
      end_of_test();
    end
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic count(input int n);
    n_sys = 0;
    n_sub = 0;
    repeat (n) begin
      @(negedge clk);
      n_sys += int'(sys_en === 1'b1);
      n_sub += int'(sub_en === 1'b1);
    end
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, psel, penable, pwrite, halt, wake, wdt_en, vdet_en} = 8'h80;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (100) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    apb(1'b1, 12'h000, 32'h0000_00FF);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(rd, 32'h0000_00EF);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check({rd[0], err}, 2'b01);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h000, {24'h0, c[2:0], 5'h00});
      repeat (64) @(posedge clk);
      check(hrc_on, c >= 2);
      count(512);
      e = (c < 2) ? 64 : 512 / (2 << (8 - c));
      check(n_sys >= e - 1 && n_sys <= e + 1, 1'b1);
    end
    apb(1'b1, 12'h000, 32'h0000_0001);
    for (int t = 0; t < 20 && rd[2] !== 1'b1; t++) begin
      apb(1'b0, 12'h000, 32'h0000_0000);
    end
    check(rd[2], 1'b1);
    count(512);
    check(n_sys >= 255 && n_sys <= 257, 1'b1);
    for (int k = 0; k < 5; k++) begin
      wdt_en <= (k == 1);
      vdet_en <= (k == 2);
      apb(1'b1, 12'h004, {24'h0, k == 4, 7'h00});
      apb(1'b1, 12'h000, {30'h0, k >= 3, 1'b1});
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      count(32);
      check(mode, exp_mode[k]);
      check({cpu_run, power_down_flag, tof}, 3'b010);
      check(n_sys > 0, k == 4);
      check(n_sub > 0, k != 0);
      apb(1'b0, 12'h008, 32'h0000_0000);
      check(rd[3:0], {1'b1, exp_mode[k]});
      apb(1'b0, 12'h000, 32'h0000_0000);
      check(rd[3], k != 0);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (40) @(posedge clk);
      check(mode, 3'h0);
    end
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule
